//--- srlwa_fifo.sv
// word fifo with registered head between aligner and fabric
`timescale 1ns/1ns
`default_nettype none
module srlwa_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  input wire logic out_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [AW:0] cnt, next_cnt;
  logic next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic push, pop;
  // head register reloads from memory when it is empty or being taken and memory holds a word
  always_comb
  begin
    in_ready = (cnt != DEPTH[AW:0]);
    push = in_valid && in_ready;
    pop = (cnt != '0) && (!out_valid || out_ready);
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_out_valid = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid);
    next_out_data = pop ? mem[rptr] : out_data;
  end
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wptr] <= in_data;
    if (rst)
    begin
      wptr <= '0;
      rptr <= '0;
      cnt <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      cnt <= next_cnt;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end
endmodule
`default_nettype wire

//--- srlwa_pkg.sv
// shared constants and types of the receive lock and word-align front end
// Operation
// - power down pll when channel unused
// - active-low pll locked-to-reference status output
// - auto data lock needs ppm and phase
// - force inputs override lock mode selection
// - unconnected force inputs mean automatic mode
// - frequency-locked output while locked to data
// - run-length limit in steps of 5/4
// - deserialize 8/10-bit words, first bit lsb
// - each bit-slip request shifts boundary one bit
// - bit-slip: 8/10-bit, custom or sonet only
// - pattern detector stays active during bit-slip
// - 16-bit mode finds and locks pattern
// - realign input restarts 16-bit search
// - 16-bit mode: 8-bit path, custom/sonet
// - four-byte pattern only in sonet mode
// - 10-bit pattern, full or low seven
// - match both disparities of 10-bit pattern
// - 10-bit mode enable input, custom only
// - fixed modes only with their own protocol
`default_nettype none
package srlwa_pkg;
  // lock-mode states, one-hot
  typedef enum logic [1:0] {LK_REF = 2'b01, LK_DATA = 2'b10} srlwa_lock_t;
  // aligner modes and protocol modes
  localparam logic [2:0] AM_BITSLIP = 3'h0;
  localparam logic [2:0] AM_16BIT = 3'h1;
  localparam logic [2:0] AM_10BIT = 3'h2;
  localparam logic [2:0] AM_XAUI = 3'h3;
  localparam logic [2:0] AM_GIGABIT_ETHERNET_MODE = 3'h4;
  localparam logic [1:0] PR_CUSTOM = 2'h0;
  localparam logic [1:0] PR_SONET = 2'h1;
  localparam logic [1:0] PR_XAUI = 2'h2;
  localparam logic [1:0] PR_GIGABIT_ETHERNET_MODE = 2'h3;
  // ppm thresholds selected by ppm_sel, and phase limit in milli-UI (.08 UI)
  localparam logic [10:0] PPM_125 = 11'h07D;
  localparam logic [10:0] PPM_250 = 11'h0FA;
  localparam logic [10:0] PPM_500 = 11'h1F4;
  localparam logic [10:0] PPM_1000 = 11'h3E8;
  localparam logic [9:0] PHASE_MAX_MUI = 10'h050;
  // run-length step per limit code
  localparam logic [2:0] RL_STEP_10B = 3'h5;
  localparam logic [2:0] RL_STEP_8B = 3'h4;
  // fixed comma for xaui and gigabit ethernet modes, matched on seven bits
  localparam logic [9:0] COMMA_PAT = 10'h17C;
  localparam logic [9:0] MASK_FULL = 10'h3FF;
  localparam logic [9:0] MASK_LOW7 = 10'h07F;
  localparam int HIST_W = 32;
endpackage
`default_nettype wire

//--- srlwa_top.sv
// receive lock-mode control, run-length check, deserializer and word aligner
`timescale 1ns/1ns
`default_nettype none
module srlwa_top
  import srlwa_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // recovered serial bit, one per mclk
  input wire logic rx_sdata,
  // pll and clock_recovery_unit status and overrides
  input wire logic chan_used,
  input wire logic pll_lock_raw,
  input wire logic [10:0] freq_off_ppm,
  input wire logic [9:0] phase_err_mui,
  input wire logic [1:0] ppm_sel,
  input wire logic force_data_lock,
  input wire logic force_ref_lock,
  output logic pll_pwr_down,
  output logic rx_locked_n,
  output logic freq_locked,
  // aligner configuration
  input wire logic [1:0] protocol,
  input wire logic [2:0] align_mode,
  input wire logic width_10b,
  input wire logic dbl_width,
  input wire logic [4:0] rl_code,
  input wire logic [9:0] pat_10,
  input wire logic mask_low7,
  input wire logic [15:0] pat_16,
  input wire logic pat_sel32,
  output logic cfg_err,
  // aligner control
  input wire logic bitslip,
  input wire logic realign,
  input wire logic align_en,
  output logic rx_aligned,
  // word output
  output logic [19:0] rx_data,
  output logic rx_pat_det,
  output logic rx_rl_viol,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_overflow
);
  // synchronisers for pin inputs
  logic [1:0] sd_sync, lk_sync;
  logic sbit, pll_lock_s;
  always_ff @(posedge mclk)
  begin
    sd_sync <= {sd_sync[0], rx_sdata};
    lk_sync <= {lk_sync[0], pll_lock_raw};
  end
  assign sbit = sd_sync[1];
  assign pll_lock_s = lk_sync[1];

  // lock-mode selection; overrides have no port default, an unconnected z fails the if tests, giving auto
  srlwa_lock_t lk_state, next_lk_state;
  logic [10:0] ppm_thr;
  logic in_ppm, in_phase;
  always_comb
  begin
    unique case (ppm_sel)
      2'h0: ppm_thr = PPM_125;
      2'h1: ppm_thr = PPM_250;
      2'h2: ppm_thr = PPM_500;
      2'h3: ppm_thr = PPM_1000;
    endcase
    in_ppm = freq_off_ppm <= ppm_thr;
    in_phase = phase_err_mui <= PHASE_MAX_MUI;
    next_lk_state = lk_state;
    if (!chan_used)
      next_lk_state = LK_REF;
    else if (force_data_lock)
      next_lk_state = LK_DATA;
    else if (force_ref_lock)
      next_lk_state = LK_REF;
    else
    begin
      // auto mode
      unique case (lk_state)
        LK_REF: if (in_ppm && in_phase) next_lk_state = LK_DATA;
        LK_DATA: if (!in_ppm) next_lk_state = LK_REF;
        default: next_lk_state = LK_REF;
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lk_state <= LK_REF;
      pll_pwr_down <= 1'b1;
      rx_locked_n <= 1'b1;
      freq_locked <= 1'b0;
    end
    else
    begin
      lk_state <= next_lk_state;
      pll_pwr_down <= !chan_used;
      rx_locked_n <= !(pll_lock_s && chan_used);
      freq_locked <= (lk_state == LK_DATA);
    end
  end

  // mode legality; an illegal mix freezes alignment
  logic cust_sonet, next_cfg_err;
  always_comb
  begin
    cust_sonet = (protocol == PR_CUSTOM) || (protocol == PR_SONET);
    unique case (align_mode)
      AM_BITSLIP: next_cfg_err = !cust_sonet;
      AM_16BIT: next_cfg_err = !cust_sonet || width_10b || (pat_sel32 && protocol != PR_SONET);
      AM_10BIT: next_cfg_err = protocol != PR_CUSTOM;
      AM_XAUI: next_cfg_err = protocol != PR_XAUI;
      AM_GIGABIT_ETHERNET_MODE: next_cfg_err = protocol != PR_GIGABIT_ETHERNET_MODE;
      default: next_cfg_err = 1'b1;
    endcase
  end

  // bit history: newest bit at the top, so older bits land in lower positions
  logic [HIST_W-1:0] hist;
  logic [9:0] w10, pat, msk;
  logic m10, m16, match, fixed_mode, align_ok, slip_req, bitslip_q;
  logic [3:0] bit_cnt, next_bit_cnt, wlast;
  logic word_end, next_aligned;
  always_comb
  begin
    w10 = hist[31:22];
    fixed_mode = (align_mode == AM_XAUI) || (align_mode == AM_GIGABIT_ETHERNET_MODE);
    pat = fixed_mode ? COMMA_PAT : pat_10;
    msk = (fixed_mode || mask_low7) ? MASK_LOW7 : MASK_FULL;
    m10 = (((w10 ^ pat) & msk) == '0) || (((w10 ^ ~pat) & msk) == '0);
    m16 = pat_sel32 ? (hist == {pat_16[15:8], pat_16[15:8], pat_16[7:0], pat_16[7:0]})
                    : (hist[31:16] == pat_16);
    // bit-slip keeps detecting with the width in use
    if (align_mode == AM_16BIT || (align_mode == AM_BITSLIP && !width_10b))
      match = width_10b ? m10 : (align_mode == AM_16BIT ? m16 : hist[31:24] == pat_16[7:0]);
    else
      match = m10;
    unique case (align_mode)
      AM_16BIT: align_ok = !rx_aligned;
      AM_10BIT: align_ok = align_en;
      AM_XAUI, AM_GIGABIT_ETHERNET_MODE: align_ok = 1'b1;
      default: align_ok = 1'b0;
    endcase
    align_ok = align_ok && !cfg_err;
    wlast = width_10b ? 4'h9 : 4'h7;
    slip_req = (align_mode == AM_BITSLIP) && !cfg_err && bitslip && !bitslip_q;
    word_end = (align_ok && match) || (bit_cnt == wlast && !slip_req);
    if (word_end)
      next_bit_cnt = 4'h0;
    else if (slip_req)
      next_bit_cnt = bit_cnt;
    else
      next_bit_cnt = bit_cnt + 4'h1;
    next_aligned = rx_aligned;
    if (align_ok && match)
      next_aligned = 1'b1;
    if (align_mode == AM_BITSLIP)
      next_aligned = !cfg_err;
    if (cfg_err || (align_mode == AM_16BIT && realign))
      next_aligned = 1'b0;
  end

  // run-length counter, limit scaled by the data width
  logic [7:0] run_cnt, next_run_cnt, rl_limit;
  logic rl_hit, next_rl_hit, last_bit;
  always_comb
  begin
    // eight-bit product: the top code plus one, times five, is 160, which a narrower product would wrap
    rl_limit = (8'(rl_code) + 8'h01) * (width_10b ? 8'(RL_STEP_10B) : 8'(RL_STEP_8B));
    next_run_cnt = (sbit == last_bit) ? ((run_cnt == 8'hFF) ? run_cnt : run_cnt + 8'h1) : 8'h1;
    next_rl_hit = (word_end ? 1'b0 : rl_hit) || (next_run_cnt > rl_limit);
  end

  // word assembly and pairing for double width
  logic [9:0] wrd, lo_wrd, next_lo_wrd;
  logic lo_pat, lo_rl, half, next_half, next_lo_pat, next_lo_rl;
  logic push, fifo_in_ready, cur_rl;
  logic [21:0] push_data;
  always_comb
  begin
    wrd = width_10b ? w10 : {2'h0, hist[31:24]};
    cur_rl = rl_hit; // the bit now entering belongs to the next word
    next_half = half;
    next_lo_wrd = lo_wrd;
    next_lo_pat = lo_pat;
    next_lo_rl = lo_rl;
    push = 1'b0;
    push_data = {cur_rl, match, 10'h000, wrd};
    if (word_end)
    begin
      if (dbl_width && !half)
      begin
        next_half = 1'b1;
        next_lo_wrd = wrd;
        next_lo_pat = match;
        next_lo_rl = cur_rl;
      end
      else
      begin
        next_half = 1'b0;
        push = 1'b1;
        if (dbl_width)
          push_data = {cur_rl || lo_rl, match || lo_pat,
                       width_10b ? {wrd, lo_wrd} : {4'h0, wrd[7:0], lo_wrd[7:0]}};
      end
    end
  end

  // history, counters and flags registered together
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      hist <= '0;
      bit_cnt <= 4'h0;
      bitslip_q <= 1'b0;
      rx_aligned <= 1'b0;
      cfg_err <= 1'b0;
      run_cnt <= 8'h0;
      last_bit <= 1'b0;
      rl_hit <= 1'b0;
      half <= 1'b0;
      lo_wrd <= 10'h000;
      lo_pat <= 1'b0;
      lo_rl <= 1'b0;
      rx_overflow <= 1'b0;
    end
    else
    begin
      hist <= {sbit, hist[HIST_W-1:1]};
      bit_cnt <= next_bit_cnt;
      bitslip_q <= bitslip;
      rx_aligned <= next_aligned;
      cfg_err <= next_cfg_err;
      run_cnt <= next_run_cnt;
      last_bit <= sbit;
      rl_hit <= next_rl_hit;
      half <= next_half;
      lo_wrd <= next_lo_wrd;
      lo_pat <= next_lo_pat;
      lo_rl <= next_lo_rl;
      // serial data cannot wait, so a full fifo loses the word and says so
      rx_overflow <= rx_overflow || (push && !fifo_in_ready);
    end
  end

  // output buffering toward the fabric
  logic [21:0] fifo_out;
  srlwa_fifo #(.WIDTH(22), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_ready(rx_ready),
    .out_valid(rx_valid),
    .out_data(fifo_out)
  );
  assign rx_data = fifo_out[19:0];
  assign rx_pat_det = fifo_out[20];
  assign rx_rl_viol = fifo_out[21];

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_slip_req;
    align_mode == AM_BITSLIP && !cfg_err && bitslip && !bitslip_q && bit_cnt != wlast;
  endsequence
  sequence s_forced_data;
    chan_used && force_data_lock;
  endsequence
  property p_pwr;
    !chan_used |=> pll_pwr_down && (lk_state == LK_REF);
  endproperty
  a_pwr: assert property (p_pwr) else $error("pll not powered down");
  property p_lockn;
    pll_lock_s && chan_used |=> !rx_locked_n;
  endproperty
  a_lockn: assert property (p_lockn) else $error("lock status not low");
  property p_auto;
    lk_state == LK_REF && !force_data_lock && !(in_ppm && in_phase) |=> lk_state == LK_REF;
  endproperty
  a_auto: assert property (p_auto) else $error("left reference lock early");
  property p_force;
    s_forced_data |=> lk_state == LK_DATA ##1 freq_locked;
  endproperty
  a_force: assert property (p_force) else $error("forced data lock ignored");
  property p_flock;
    freq_locked == $past(lk_state == LK_DATA);
  endproperty
  a_flock: assert property (p_flock) else $error("freq lock output wrong");
  property p_slip;
    s_slip_req |=> bit_cnt == $past(bit_cnt);
  endproperty
  a_slip: assert property (p_slip) else $error("bit slip did not hold boundary");
  property p_realign;
    align_mode == AM_16BIT && realign |=> !rx_aligned;
  endproperty
  a_realign: assert property (p_realign) else $error("realign not honoured");
  property p_sonet32;
    align_mode == AM_16BIT && pat_sel32 && protocol == PR_CUSTOM |=> cfg_err;
  endproperty
  a_sonet32: assert property (p_sonet32) else $error("four byte pattern accepted");
  property p_rl;
    word_end && (run_cnt > rl_limit) |-> push_data[21] || (dbl_width && !half);
  endproperty
  a_rl: assert property (p_rl) else $error("run length flag lost");
endmodule
`default_nettype wire

//--- srlwa_tx_model.sv
// serial transmitter model driving the receive front end, one bit per clock
`timescale 1ns/1ns
`default_nettype none
module srlwa_tx_model (
  // clock
  input wire logic mclk,
  // serial line toward the receiver
  output logic sdata
);
  logic bit_q[$];
  initial sdata = 1'b1;
  // queued bits go out first; between frames the line toggles so no stale level passes for data
  always @(posedge mclk)
  begin
    if (bit_q.size() > 0)
      sdata <= #1 bit_q.pop_front();
    else
      sdata <= #1 ~sdata;
  end
  // queue one word of n bits, least significant bit first
  task automatic send(input logic [9:0] w, input int n);
    for (int i = 0; i < n; i++)
      bit_q.push_back(w[i]);
  endtask
endmodule
`default_nettype wire

//--- test_serdes_rx_lock_and_word_align.sv
// self-checking bench for the receive lock and word-align front end
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module test_serdes_rx_lock_and_word_align;
  import srlwa_pkg::*;
  logic mclk, rst, rx_sdata, chan_used, pll_lock_raw, force_data_lock, force_ref_lock;
  logic [10:0] freq_off_ppm;
  logic [9:0] phase_err_mui, pat_10, b;
  logic [1:0] ppm_sel, protocol;
  logic [2:0] align_mode;
  logic width_10b, dbl_width, mask_low7, pat_sel32, bitslip, realign, align_en, rx_ready;
  logic [4:0] rl_code;
  logic [15:0] pat_16;
  logic pll_pwr_down, rx_locked_n, freq_locked, cfg_err, rx_aligned, rx_pat_det, rx_rl_viol, rx_valid, rx_overflow;
  logic [19:0] rx_data;
  logic [21:0] got_q[$];
  logic [10:0] thr [4] = '{PPM_125, PPM_250, PPM_500, PPM_1000};
  // {expect cfg_err, four-byte pattern, 10-bit path, protocol, align mode}
  logic [7:0] cfg_tab [12] = '{8'hC1, 8'h49, 8'hA1, 8'hAA, 8'h22, 8'hB0, 8'h08, 8'hA3, 8'h33, 8'h3C, 8'hB4, 8'hA5};
  int failures = 0;
  int comparisons = 0;
  int k;

  srlwa_top #(.FIFO_DEPTH(16)) uut (.mclk, .rst, .rx_sdata, .chan_used, .pll_lock_raw, .freq_off_ppm,
    .phase_err_mui, .ppm_sel, .force_data_lock, .force_ref_lock, .pll_pwr_down, .rx_locked_n, .freq_locked,
    .protocol, .align_mode, .width_10b, .dbl_width, .rl_code, .pat_10, .mask_low7, .pat_16, .pat_sel32,
    .cfg_err, .bitslip, .realign, .align_en, .rx_aligned, .rx_data, .rx_pat_det, .rx_rl_viol, .rx_valid,
    .rx_ready, .rx_overflow);
  srlwa_tx_model tx (.mclk(mclk), .sdata(rx_sdata));

  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // words taken by the fabric, tagged with their pattern and run flags
  always @(posedge mclk)
  begin
    if (rx_valid && rx_ready)
      got_q.push_back({rx_pat_det, rx_rl_viol, rx_data});
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset;
    rst = 1'b1;
    tick(5);
    rst = 1'b0;
  endtask

  task automatic cfg(input logic [1:0] p, input logic [2:0] m, input logic w);
    protocol = p;
    align_mode = m;
    width_10b = w;
    tick(3);
  endtask

  // first word matching pattern flag and data, run flag ignored; 1000 when absent
  function automatic int find(input logic [21:0] e);
    find = 1000;
    for (int i = got_q.size() - 1; i >= 0; i--)
      if ({got_q[i][21], got_q[i][19:0]} === {e[21], e[19:0]})
        find = i;
  endfunction

  task automatic print_verdict;
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog: the sequence needs under a thousand cycles
  initial
  begin
    #200000;
    failures++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    {rst, chan_used, pll_lock_raw, force_data_lock, force_ref_lock, bitslip, realign, align_en} = 8'h80;
    {freq_off_ppm, phase_err_mui, ppm_sel, protocol, align_mode} = '0;
    {width_10b, dbl_width, rl_code, mask_low7, pat_sel32} = '0;
    pat_10 = 10'h17C;
    pat_16 = 16'h1BE4;
    rx_ready = 1'b1;
    do_reset();
    `CHK("pwr_down", 1'b1, pll_pwr_down)
    `CHK("locked_n", 1'b1, rx_locked_n)
    chan_used = 1'b1;
    pll_lock_raw = 1'b1;
    phase_err_mui = 10'h050;
    tick(5);
    `CHK("pwr_down", 1'b0, pll_pwr_down)
    `CHK("locked_n", 1'b0, rx_locked_n)
    // each ppm threshold at its edge and one beyond
    for (k = 0; k < 4; k++)
    begin
      ppm_sel = k[1:0];
      freq_off_ppm = thr[k];
      tick(4);
      `CHK("auto_in", 1'b1, freq_locked)
      freq_off_ppm = thr[k] + 11'h001;
      tick(4);
      `CHK("auto_out", 1'b0, freq_locked)
    end
    freq_off_ppm = 11'h000;
    phase_err_mui = 10'h051;
    tick(4);
    `CHK("phase_out", 1'b0, freq_locked)
    phase_err_mui = 10'h050;
    tick(4);
    `CHK("auto_default", 1'b1, freq_locked)
    force_ref_lock = 1'b1;
    tick(4);
    `CHK("force_ref", 1'b0, freq_locked)
    force_data_lock = 1'b1;
    tick(4);
    `CHK("force_both", 1'b1, freq_locked)
    force_ref_lock = 1'b0;
    freq_off_ppm = 11'h7FF;
    tick(4);
    `CHK("force_data", 1'b1, freq_locked)
    force_data_lock = 1'b0;
    tick(4);
    `CHK("back_auto", 1'b0, freq_locked)
    chan_used = 1'b0;
    tick(4);
    `CHK("pwr_down", 1'b1, pll_pwr_down)
    `CHK("locked_n", 1'b1, rx_locked_n)
    chan_used = 1'b1;
    // mode, protocol and width combinations
    for (k = 0; k < 12; k++)
    begin
      {pat_sel32, width_10b, protocol, align_mode} = cfg_tab[k][6:0];
      tick(3);
      `CHK("cfg_err", cfg_tab[k][7], cfg_err)
    end
    pat_sel32 = 1'b0;
    // 10-bit alignment: suspended, then pattern, run-length and both disparities
    cfg(PR_CUSTOM, AM_10BIT, 1'b1);
    do_reset();
    tx.send(10'h17C, 10);
    tick(30);
    `CHK("held", 1'b0, rx_aligned)
    align_en = 1'b1;
    got_q.delete();
    tx.send(10'h17C, 10);
    tx.send(10'h03F, 10);
    tx.send(10'h21F, 10);
    tick(60);
    k = find(22'h20017C);
    `CHK("aligned", 1'b1, rx_aligned)
    `CHK("pat_word", 22'h20017C, got_q[k])
    `CHK("run6", 22'h10003F, got_q[k+1])
    `CHK("run5", 22'h00021F, got_q[k+2])
    mask_low7 = 1'b1;
    got_q.delete();
    tx.send(10'h2FC, 10);
    tick(40);
    `CHK("low7", 1'b1, find(22'h2002FC) < 1000)
    mask_low7 = 1'b0;
    got_q.delete();
    tx.send(10'h283, 10);
    tick(40);
    `CHK("disparity", 1'b1, find(22'h200283) < 1000)
    // 16-bit pattern lock, then a forced search at a shifted boundary
    cfg(PR_CUSTOM, AM_16BIT, 1'b0);
    do_reset();
    got_q.delete();
    tx.send(10'h0E4, 8);
    tx.send(10'h01B, 8);
    tx.send(10'h05A, 8);
    tick(50);
    k = find(22'h20001B);
    `CHK("lock16", 22'h00005A, {2'b00, got_q[k+1][19:0]})
    realign = 1'b1;
    tick(1);
    realign = 1'b0;
    got_q.delete();
    tx.send(10'h005, 3);
    tx.send(10'h0E4, 8);
    tx.send(10'h01B, 8);
    tx.send(10'h0C3, 8);
    tick(50);
    k = find(22'h20001B);
    `CHK("realign", 22'h0000C3, {2'b00, got_q[k+1][19:0]})
    // bit slip moves the boundary by one bit per request
    cfg(PR_CUSTOM, AM_BITSLIP, 1'b1);
    repeat (14) tx.send(10'h2C7, 10);
    tick(45);
    b = got_q[$][9:0];
    bitslip = 1'b1;
    tick(1);
    bitslip = 1'b0;
    tick(45);
    `CHK("slip", {b[0], b[9:1]}, got_q[$][9:0])
    // fabric stalls until the buffer refuses, then drains it
    rx_ready = 1'b0;
    tick(220);
    `CHK("overflow", 1'b1, rx_overflow)
    rx_ready = 1'b1;
    got_q.delete();
    tick(20);
    `CHK("drained", 1'b1, got_q.size() >= 16)
    // fixed comma mode locks on the seven-bit comma, the next word follows ten bits later
    cfg(PR_XAUI, AM_XAUI, 1'b1);
    got_q.delete();
    tx.send(10'h17C, 10);
    tx.send(10'h0F0, 10);
    tick(40);
    k = find(22'h20017C);
    `CHK("xaui_next", 22'h0000F0, got_q[k+1])
    // top limit code allows 160 equal bits, so a run of forty is no violation
    rl_code = 5'h1F;
    got_q.delete();
    repeat (4) tx.send(10'h3FF, 10);
    tick(60);
    b = '0;
    foreach (got_q[i])
      b[0] = b[0] | got_q[i][20];
    `CHK("long_limit", 1'b0, b[0])
    print_verdict();
  end
endmodule
`default_nettype wire
